/* bxu_exec.sv */
// branch, bit and call execute unit of an 8-bit core
// assumes operand value and its ram/system kind arrive with the instruction
module bxu_exec (
	input  wire logic                    CORE_CLK_IN,      // core clock
	input  wire logic                    SYS_RST_IN,       // sync reset, high
	input  wire logic                    INSTR_VALID_IN,   // instruction offered
	input  wire bxu_pkg::bxu_op_t        OPCODE_IN,        // decoded operation
	input  wire logic [13:0]             DEST_IN,          // jump field or immediate
	input  wire logic [2:0]              BIT_SEL_IN,       // bit index
	input  wire logic [7:0]              MEM_ADDR_IN,      // operand address
	input  wire logic [7:0]              MEM_DATA_IN,      // operand value
	input  wire logic                    MEM_IS_SYS_IN,    // operand is system register
	input  wire logic [1:0]              ROM_PAGE_IN,      // rom page select bits
	input  wire logic                    TIMER_OVF_IN,     // timer overflow status
	input  wire logic                    POWER_DOWN_IN,    // power-down status
	output logic                         BUSY_OUT,         // extra cycle in progress
	output logic [7:0]                   ACCUMULATOR_OUT,  // accumulator
	output logic [7:0]                   PROGRAM_FLAG_OUT, // flag register
	output logic [15:0]                  PC_OUT,           // program counter
	output logic                         GIE_OUT,          // global interrupt enable
	output logic                         SKIP_OUT,         // skip taken pulse
	output logic                         MEM_WR_OUT,       // memory write pulse
	output logic [7:0]                   MEM_WR_ADDR_OUT,  // write address
	output logic                         MEM_BANK0_OUT,    // write goes to bank 0
	output logic [7:0]                   MEM_WR_DATA_OUT   // write data
);
	bxu_stack_if stk ();

	bxu_stack_mem u_stack (
		.clk  (CORE_CLK_IN),
		.port (stk)
	);

	function automatic logic [7:0] bit_mask(input logic [2:0] sel);
		bit_mask = bxu_pkg::DATA_ONE << sel;
	endfunction

	logic [7:0]               accumulator;
	logic [7:0]               program_flag;
	logic [7:0]               shadow_acc;
	logic [7:0]               shadow_flag;
	logic [15:0]              pc;
	logic [bxu_pkg::SP_W-1:0] sp;
	logic [1:0]               busy_cnt;
	logic                     ret_pend;
	logic                     ret_irq;
	logic                     go;

	logic [7:0]  operand;
	logic [8:0]  cmp_sum;
	logic [7:0]  inc_val;
	logic [7:0]  dec_val;
	logic        sel_bit;
	logic        skip_cond;
	logic        wr_mem;
	logic        bank0;
	logic [7:0]  wdata;
	logic        load_acc;
	logic [7:0]  new_acc;
	logic        set_zc;
	logic        is_long;
	logic        do_push;
	logic        do_pop;
	logic [1:0]  next_busy_cnt;

	assign go      = INSTR_VALID_IN && (busy_cnt == bxu_pkg::EXTRA_NONE);
	assign operand = (OPCODE_IN == bxu_pkg::OP_COMPARE_SKIP_EQUAL_IMM) ? DEST_IN[7:0] : MEM_DATA_IN;
	// carry set means no borrow
	assign cmp_sum = {1'b0, accumulator} + {1'b0, ~operand} + 9'h001;
	assign inc_val = MEM_DATA_IN + bxu_pkg::DATA_ONE;
	assign dec_val = MEM_DATA_IN - bxu_pkg::DATA_ONE;
	assign sel_bit = MEM_DATA_IN[BIT_SEL_IN];

	// ============================================================
	// decode
	always_comb begin
		skip_cond = 1'b0;
		wr_mem    = 1'b0;
		bank0     = 1'b0;
		wdata     = MEM_DATA_IN;
		load_acc  = 1'b0;
		new_acc   = accumulator;
		set_zc    = 1'b0;
		is_long   = 1'b0;
		do_push   = 1'b0;
		do_pop    = 1'b0;
		unique case (OPCODE_IN)
			bxu_pkg::OP_NO_OP: begin
			end
			bxu_pkg::OP_COMPARE_SKIP_EQUAL_IMM,
			bxu_pkg::OP_COMPARE_SKIP_EQUAL_MEM: begin
				set_zc    = 1'b1;
				skip_cond = (cmp_sum[7:0] == bxu_pkg::DATA_RESET);
			end
			bxu_pkg::OP_INC_TO_ACC_SKIP_ZERO: begin
				load_acc  = 1'b1;
				new_acc   = inc_val;
				skip_cond = (inc_val == bxu_pkg::DATA_RESET);
			end
			bxu_pkg::OP_DEC_TO_ACC_SKIP_ZERO: begin
				load_acc  = 1'b1;
				new_acc   = dec_val;
				skip_cond = (dec_val == bxu_pkg::DATA_RESET);
			end
			bxu_pkg::OP_INC_MEM_SKIP_ZERO: begin
				wr_mem    = 1'b1;
				wdata     = inc_val;
				skip_cond = (inc_val == bxu_pkg::DATA_RESET);
			end
			bxu_pkg::OP_DEC_MEM_SKIP_ZERO: begin
				wr_mem    = 1'b1;
				wdata     = dec_val;
				skip_cond = (dec_val == bxu_pkg::DATA_RESET);
			end
			bxu_pkg::OP_BIT_TEST_SKIP_CLEAR: skip_cond = !sel_bit;
			bxu_pkg::OP_BIT_TEST_SKIP_SET:   skip_cond = sel_bit;
			bxu_pkg::OP_BANK0_BIT_TEST_SKIP_CLEAR: begin
				bank0     = 1'b1;
				skip_cond = !sel_bit;
			end
			bxu_pkg::OP_BANK0_BIT_TEST_SKIP_SET: begin
				bank0     = 1'b1;
				skip_cond = sel_bit;
			end
			bxu_pkg::OP_BIT_CLEAR, bxu_pkg::OP_BANK0_BIT_CLEAR: begin
				wr_mem = 1'b1;
				bank0  = (OPCODE_IN == bxu_pkg::OP_BANK0_BIT_CLEAR);
				wdata  = MEM_DATA_IN & ~bit_mask(BIT_SEL_IN);
			end
			bxu_pkg::OP_BIT_SET, bxu_pkg::OP_BANK0_BIT_SET: begin
				wr_mem = 1'b1;
				bank0  = (OPCODE_IN == bxu_pkg::OP_BANK0_BIT_SET);
				wdata  = MEM_DATA_IN | bit_mask(BIT_SEL_IN);
			end
			bxu_pkg::OP_JUMP: is_long = 1'b1;
			bxu_pkg::OP_CALL: begin
				is_long = 1'b1;
				do_push = 1'b1;
			end
			bxu_pkg::OP_SUBROUTINE_RETURN, bxu_pkg::OP_INTERRUPT_RETURN: begin
				is_long = 1'b1;
				do_pop  = 1'b1;
			end
			bxu_pkg::OP_CONTEXT_SAVE, bxu_pkg::OP_CONTEXT_RESTORE: begin
			end
			default: begin
			end
		endcase
	end

	// ram write and taken skip each cost one cycle; long ops cost one
	assign next_busy_cnt = go ? ((wr_mem && !MEM_IS_SYS_IN) ? bxu_pkg::EXTRA_ONE : bxu_pkg::EXTRA_NONE)
		+ (skip_cond ? bxu_pkg::EXTRA_ONE : bxu_pkg::EXTRA_NONE)
		+ (is_long ? bxu_pkg::EXTRA_ONE : bxu_pkg::EXTRA_NONE)
		: ((busy_cnt == bxu_pkg::EXTRA_NONE) ? bxu_pkg::EXTRA_NONE : busy_cnt - bxu_pkg::EXTRA_ONE);

	// ============================================================
	// stack port: the return address is the instruction after the call
	assign stk.wr_en   = go && do_push;
	assign stk.wr_addr = sp;
	assign stk.wr_data = pc + bxu_pkg::PC_STEP;
	assign stk.rd_addr = sp - bxu_pkg::SP_ONE;

	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			sp <= '0;
		end else if (go && do_push) begin
			sp <= sp + bxu_pkg::SP_ONE;
		end else if (go && do_pop) begin
			sp <= sp - bxu_pkg::SP_ONE;
		end
	end

	// ============================================================
	// cycle accounting
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			busy_cnt <= bxu_pkg::EXTRA_NONE;
			BUSY_OUT <= 1'b0;
		end else begin
			busy_cnt <= next_busy_cnt;
			BUSY_OUT <= (next_busy_cnt != bxu_pkg::EXTRA_NONE);
		end
	end

	// ============================================================
	// program counter and interrupt enable
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			pc       <= bxu_pkg::PC_RESET;
			ret_pend <= 1'b0;
			ret_irq  <= 1'b0;
			GIE_OUT  <= 1'b0;
			SKIP_OUT <= 1'b0;
		end else begin
			ret_pend <= go && do_pop;
			ret_irq  <= go && (OPCODE_IN == bxu_pkg::OP_INTERRUPT_RETURN);
			SKIP_OUT <= go && skip_cond;
			if (ret_pend) begin
				pc <= stk.rd_data;
				if (ret_irq) begin
					GIE_OUT <= 1'b1;
				end
			end else if (go && is_long && !do_pop) begin
				pc <= {ROM_PAGE_IN, DEST_IN};
			end else if (go && skip_cond) begin
				pc <= pc + bxu_pkg::PC_SKIP_STEP;
			end else if (go && !do_pop) begin
				pc <= pc + bxu_pkg::PC_STEP;
			end
		end
	end
	assign PC_OUT = pc;

	// ============================================================
	// accumulator, flags and shadow buffers
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			accumulator  <= bxu_pkg::DATA_RESET;
			program_flag <= bxu_pkg::FLAG_RESET;
			shadow_acc   <= bxu_pkg::DATA_RESET;
			shadow_flag  <= bxu_pkg::FLAG_RESET;
		end else begin
			// status bits always track their sources, never the pop
			program_flag[bxu_pkg::FLAG_TOV_BIT] <= TIMER_OVF_IN;
			program_flag[bxu_pkg::FLAG_PD_BIT]  <= POWER_DOWN_IN;
			if (go && set_zc) begin
				program_flag[bxu_pkg::FLAG_Z_BIT] <= (cmp_sum[7:0] == bxu_pkg::DATA_RESET);
				program_flag[bxu_pkg::FLAG_C_BIT] <= cmp_sum[8];
			end
			if (go && load_acc) begin
				accumulator <= new_acc;
			end
			if (go && OPCODE_IN == bxu_pkg::OP_CONTEXT_SAVE) begin
				shadow_acc  <= accumulator;
				shadow_flag <= program_flag & ~bxu_pkg::FLAG_STATUS_MASK;
			end
			if (go && OPCODE_IN == bxu_pkg::OP_CONTEXT_RESTORE) begin
				accumulator <= shadow_acc;
				program_flag[bxu_pkg::FLAG_Z_BIT]  <= shadow_flag[bxu_pkg::FLAG_Z_BIT];
				program_flag[bxu_pkg::FLAG_DC_BIT] <= shadow_flag[bxu_pkg::FLAG_DC_BIT];
				program_flag[bxu_pkg::FLAG_C_BIT]  <= shadow_flag[bxu_pkg::FLAG_C_BIT];
			end
		end
	end
	assign ACCUMULATOR_OUT  = accumulator;
	assign PROGRAM_FLAG_OUT = program_flag;

	// ============================================================
	// memory write port
	always_ff @(posedge CORE_CLK_IN) begin
		if (SYS_RST_IN) begin
			MEM_WR_OUT      <= 1'b0;
			MEM_WR_ADDR_OUT <= bxu_pkg::DATA_RESET;
			MEM_BANK0_OUT   <= 1'b0;
			MEM_WR_DATA_OUT <= bxu_pkg::DATA_RESET;
		end else begin
			MEM_WR_OUT <= go && wr_mem;
			if (go) begin
				MEM_WR_ADDR_OUT <= MEM_ADDR_IN;
				MEM_BANK0_OUT   <= bank0;
				MEM_WR_DATA_OUT <= wdata;
			end
		end
	end

	// ============================================================
	// checks
	sequence s_two_cycle;
		BUSY_OUT ##1 !BUSY_OUT;
	endsequence

	a_cmp_skip_equal: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_COMPARE_SKIP_EQUAL_IMM && accumulator == DEST_IN[7:0]
		|=> pc == $past(pc) + bxu_pkg::PC_SKIP_STEP && program_flag[bxu_pkg::FLAG_Z_BIT]
		&& accumulator == $past(accumulator) && SKIP_OUT)
		else $error("compare equal did not skip");
	a_cmp_mem_flags: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_COMPARE_SKIP_EQUAL_MEM && accumulator < MEM_DATA_IN
		|=> !program_flag[bxu_pkg::FLAG_C_BIT] && !SKIP_OUT && !MEM_WR_OUT)
		else $error("compare borrow wrong");
	a_inc_acc_zero: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_INC_TO_ACC_SKIP_ZERO && MEM_DATA_IN == 8'hFF
		|=> accumulator == bxu_pkg::DATA_RESET && SKIP_OUT && !MEM_WR_OUT)
		else $error("increment to accumulator wrong");
	a_dec_mem_write: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_DEC_MEM_SKIP_ZERO && MEM_DATA_IN == bxu_pkg::DATA_ONE
		&& !MEM_IS_SYS_IN |=> MEM_WR_OUT && MEM_WR_DATA_OUT == bxu_pkg::DATA_RESET
		##1 BUSY_OUT ##1 !BUSY_OUT)
		else $error("memory decrement cost wrong");
	a_bit_test_skip: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_BIT_TEST_SKIP_SET && !sel_bit
		|=> pc == $past(pc) + bxu_pkg::PC_STEP && !BUSY_OUT)
		else $error("bit test skipped wrongly");
	a_bank0_set: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_BANK0_BIT_SET && MEM_IS_SYS_IN
		|=> MEM_WR_OUT && MEM_BANK0_OUT && !BUSY_OUT
		&& MEM_WR_DATA_OUT == ($past(MEM_DATA_IN) | bit_mask($past(BIT_SEL_IN))))
		else $error("bank0 bit set wrong");
	a_jump_target: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_JUMP
		|=> pc == {$past(ROM_PAGE_IN), $past(DEST_IN)} and s_two_cycle)
		else $error("jump target or cost wrong");
	a_call_push: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_CALL |-> stk.wr_en && stk.wr_data == pc + bxu_pkg::PC_STEP
		##1 s_two_cycle)
		else $error("call push wrong");
	a_int_return: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_INTERRUPT_RETURN
		|=> BUSY_OUT ##1 !BUSY_OUT && GIE_OUT && pc == $past(stk.rd_data))
		else $error("interrupt return wrong");
	a_sub_return: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_SUBROUTINE_RETURN
		|=> ##1 GIE_OUT == $past(GIE_OUT, 2) && pc == $past(stk.rd_data))
		else $error("subroutine return wrong");
	a_context_restore: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_CONTEXT_RESTORE
		|=> accumulator == $past(shadow_acc) && !BUSY_OUT
		&& program_flag[bxu_pkg::FLAG_TOV_BIT] == $past(TIMER_OVF_IN))
		else $error("context restore wrong");
	a_no_op_still: assert property (@(posedge CORE_CLK_IN) disable iff (SYS_RST_IN)
		go && OPCODE_IN == bxu_pkg::OP_NO_OP
		|=> $stable(accumulator) && !MEM_WR_OUT && !BUSY_OUT && pc == $past(pc) + bxu_pkg::PC_STEP)
		else $error("no-operation changed state");
endmodule

/* bxu_pkg.sv */
// constants, opcode set and flag layout for the branch, bit and call execute unit
// assumes one core clock, synchronous active-high reset, operands fetched upstream
// ============================================================
// Contract
// - compare with immediate: flags from subtraction, accumulator kept, skip when equal
// - compare with memory: zero and carry only, skip when accumulator equals operand
// - increment/decrement into accumulator, memory kept, skip when result is zero
// - increment/decrement memory in place, skip on zero, cost one plus write plus skip
// - bit test skips when selected bit is 0 or 1 respectively
// - bank-0 bit tests use bank 0 whatever bank is selected
// - bit clear/set force one bit, bank-0 forms use bank 0, flags untouched
// - jump loads page bits into pc 15:14 and destination into 13:0, two cycles
// - call pushes the full 16-bit pc plus one, then jumps like jump, two cycles
// - interrupt return pops pc and sets global interrupt enable, two cycles
// - context save copies accumulator and flags except status bits, one cycle
// - context restore reloads accumulator and flags, status bits untouched, one cycle
// - memory write adds a cycle for general RAM, none for system registers
// - taken skip adds one cycle, untaken skip adds none
// - no-operation changes nothing and takes one cycle
package bxu_pkg;
	localparam int unsigned DATA_W     = 8;
	localparam int unsigned PC_W       = 16;
	localparam int unsigned DEST_W     = 14;
	localparam int unsigned PAGE_W     = 2;
	localparam int unsigned BIT_SEL_W  = 3;
	localparam int unsigned SP_W       = 3;
	localparam int unsigned STACK_DEPTH = 8;
	localparam int unsigned CNT_W      = 2;

	// ============================================================
	// flag register layout
	localparam int unsigned FLAG_Z_BIT   = 0;
	localparam int unsigned FLAG_DC_BIT  = 1;
	localparam int unsigned FLAG_C_BIT   = 2;
	localparam int unsigned FLAG_PD_BIT  = 6;
	localparam int unsigned FLAG_TOV_BIT = 7;
	localparam logic [7:0]  FLAG_STATUS_MASK = 8'hC0;
	localparam logic [7:0]  FLAG_RESET   = 8'h00;
	localparam logic [7:0]  DATA_RESET   = 8'h00;
	localparam logic [7:0]  DATA_ONE     = 8'h01;
	localparam logic [15:0] PC_RESET     = 16'h0000;
	localparam logic [15:0] PC_STEP      = 16'h0001;
	localparam logic [15:0] PC_SKIP_STEP = 16'h0002;
	localparam logic [2:0]  SP_ONE       = 3'h1;
	localparam logic [1:0]  EXTRA_ONE    = 2'h1;
	localparam logic [1:0]  EXTRA_NONE   = 2'h0;

	// ============================================================
	// decoded instruction set of this unit
	typedef enum logic [4:0] {
		OP_NO_OP,
		OP_COMPARE_SKIP_EQUAL_IMM,
		OP_COMPARE_SKIP_EQUAL_MEM,
		OP_INC_TO_ACC_SKIP_ZERO,
		OP_DEC_TO_ACC_SKIP_ZERO,
		OP_INC_MEM_SKIP_ZERO,
		OP_DEC_MEM_SKIP_ZERO,
		OP_BIT_TEST_SKIP_CLEAR,
		OP_BIT_TEST_SKIP_SET,
		OP_BANK0_BIT_TEST_SKIP_CLEAR,
		OP_BANK0_BIT_TEST_SKIP_SET,
		OP_BIT_CLEAR,
		OP_BIT_SET,
		OP_BANK0_BIT_CLEAR,
		OP_BANK0_BIT_SET,
		OP_JUMP,
		OP_CALL,
		OP_SUBROUTINE_RETURN,
		OP_INTERRUPT_RETURN,
		OP_CONTEXT_SAVE,
		OP_CONTEXT_RESTORE
	} bxu_op_t;
endpackage

/* bxu_stack_if.sv */
// return stack port between the execute unit and its stack memory
// assumes both ends on the core clock
interface bxu_stack_if;
	logic                        wr_en;
	logic [bxu_pkg::SP_W-1:0]    wr_addr;
	logic [bxu_pkg::PC_W-1:0]    wr_data;
	logic [bxu_pkg::SP_W-1:0]    rd_addr;
	logic [bxu_pkg::PC_W-1:0]    rd_data;

	modport core (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* bxu_stack_mem.sv */
// return stack storage, one write port and a registered read port
// assumes the owner keeps the pointer; overflow simply wraps
module bxu_stack_mem (
	input  wire logic  clk,   // core clock
	bxu_stack_if.mem   port   // stack access
);
	logic [bxu_pkg::PC_W-1:0] mem [bxu_pkg::STACK_DEPTH];

	always_ff @(posedge clk) begin
		if (port.wr_en) begin
			mem[port.wr_addr] <= port.wr_data;
		end
	end

	// registered read: popped value is usable one cycle after the address
	always_ff @(posedge clk) begin
		port.rd_data <= mem[port.rd_addr];
	end
endmodule

/* test_mcu_branch_bit_call_exec.sv */
// self-checking bench for the branch, bit and call execute unit
// assumes bxu_pkg and bxu_exec are compiled first; bench drives all ports
module test_mcu_branch_bit_call_exec;
	timeunit 1ns;
	timeprecision 1ps;

	logic                clk = 1'b0;
	logic                rst = 1'b1;
	logic                vld = 1'b0;
	bxu_pkg::bxu_op_t    op = bxu_pkg::OP_NO_OP;
	logic [13:0]         dest = 14'h0000;
	logic [2:0]          bsel = 3'h0;
	logic [7:0]          maddr = 8'h00;
	logic [7:0]          mdata = 8'h00;
	logic                msys = 1'b0;
	logic [1:0]          page = 2'h0;
	logic                tovf = 1'b0;
	logic                pdn = 1'b0;
	logic                busy, gie, skip, mwr, bank0;
	logic [7:0]          acc, flg, waddr, wdata;
	logic [15:0]         pc;
	logic [15:0]         exp_pc = 16'h0000;
	logic [15:0]         rstk[$];
	logic                s_bank0;
	int                  num_errors = 0;
	int                  n_checks = 0;

	always #25 clk = ~clk;

	bxu_exec i_dut (.CORE_CLK_IN(clk), .SYS_RST_IN(rst), .INSTR_VALID_IN(vld),
		.OPCODE_IN(op), .DEST_IN(dest), .BIT_SEL_IN(bsel), .MEM_ADDR_IN(maddr),
		.MEM_DATA_IN(mdata), .MEM_IS_SYS_IN(msys), .ROM_PAGE_IN(page),
		.TIMER_OVF_IN(tovf), .POWER_DOWN_IN(pdn), .BUSY_OUT(busy),
		.ACCUMULATOR_OUT(acc), .PROGRAM_FLAG_OUT(flg), .PC_OUT(pc), .GIE_OUT(gie),
		.SKIP_OUT(skip), .MEM_WR_OUT(mwr), .MEM_WR_ADDR_OUT(waddr),
		.MEM_BANK0_OUT(bank0), .MEM_WR_DATA_OUT(wdata));

	// ==========
	// compare and report
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] want);
		n_checks++;
		if (seen !== want) begin
			num_errors++;
			$display("mismatch %s expected %h seen %h", what, want, seen);
		end
	endtask

	task automatic stop_test();
		if (num_errors == 0 && n_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask

	// ==========
	// one instruction: offer, look at the answer cycle, count busy cycles
	task automatic run(input bxu_pkg::bxu_op_t o, input logic [13:0] d, input logic [2:0] b,
			input logic [7:0] m, input logic s, input logic es, input logic ew,
			input logic [7:0] ewd, input int ex);
		int n;
		@(posedge clk); #1;
		vld = 1'b1; op = o; dest = d; bsel = b; mdata = m; msys = s; maddr = m ^ 8'h3C;
		case (o)
			bxu_pkg::OP_JUMP: exp_pc = {page, d};
			bxu_pkg::OP_CALL: begin
				rstk.push_back(exp_pc + 16'h0001);
				exp_pc = {page, d};
			end
			bxu_pkg::OP_SUBROUTINE_RETURN, bxu_pkg::OP_INTERRUPT_RETURN: exp_pc = rstk.pop_back();
			default: exp_pc = exp_pc + (es ? 16'h0002 : 16'h0001);
		endcase
		@(posedge clk); #1;
		vld = 1'b0;
		check("skip", {15'h0, skip}, {15'h0, es});
		check("mem_wr", {15'h0, mwr}, {15'h0, ew});
		if (ew) begin
			check("wr_data", {8'h0, wdata}, {8'h0, ewd});
			check("wr_addr", {8'h0, waddr}, {8'h0, m ^ 8'h3C});
		end
		s_bank0 = bank0;
		n = 0;
		while (busy === 1'b1 && n < 8) begin
			@(posedge clk); #1;
			n++;
		end
		check("extra", 16'(n), 16'(ex));
		check("pc", pc, exp_pc);
	endtask

	// ==========
	// scenarios
	task automatic t_reset();
		check("rst_out", {busy, gie, skip, mwr, acc, 4'h0}, 16'h0000);
		check("rst_pc", pc, 16'h0000);
		check("rst_flg", {8'h0, flg}, 16'h0000);
	endtask

	task automatic t_acc();
		run(bxu_pkg::OP_DEC_TO_ACC_SKIP_ZERO, 14'h0, 3'h0, 8'h01, 1'b0, 1, 0, 8'h0, 1);
		run(bxu_pkg::OP_INC_TO_ACC_SKIP_ZERO, 14'h0, 3'h0, 8'hFF, 1'b0, 1, 0, 8'h0, 1);
		check("acc", {8'h0, acc}, 16'h0000);
		run(bxu_pkg::OP_INC_TO_ACC_SKIP_ZERO, 14'h0, 3'h0, 8'h41, 1'b0, 0, 0, 8'h0, 0);
		check("acc", {8'h0, acc}, 16'h0042);
	endtask

	task automatic t_nop();
		logic [7:0] a, f;
		a = acc;
		f = flg;
		run(bxu_pkg::OP_NO_OP, 14'h3FFF, 3'h7, 8'hFF, 1'b0, 0, 0, 8'h0, 0);
		check("nop_acc", {acc, flg}, {a, f});
		// an undefined code must behave as a no-operation
		run(bxu_pkg::bxu_op_t'(5'h1F), 14'h0, 3'h0, 8'h00, 1'b0, 0, 0, 8'h0, 0);
		check("bad_acc", {acc, flg}, {a, f});
	endtask

	task automatic t_compare();
		logic [7:0] v[3] = '{8'h42, 8'h50, 8'h10};
		for (int k = 0; k < 6; k++) begin
			logic [7:0] x;
			x = v[k % 3];
			if (k < 3) run(bxu_pkg::OP_COMPARE_SKIP_EQUAL_IMM, {6'h0, x}, 3'h0, ~x, 1'b0,
				x == 8'h42, 0, 8'h0, (x == 8'h42) ? 1 : 0);
			else run(bxu_pkg::OP_COMPARE_SKIP_EQUAL_MEM, {6'h0, ~x}, 3'h0, x, 1'b0,
				x == 8'h42, 0, 8'h0, (x == 8'h42) ? 1 : 0);
			check("z", {15'h0, flg[0]}, {15'h0, x == 8'h42});
			check("c", {15'h0, flg[2]}, {15'h0, x <= 8'h42});
			check("cmp_acc", {8'h0, acc}, 16'h0042);
		end
	endtask

	task automatic t_mem();
		run(bxu_pkg::OP_INC_MEM_SKIP_ZERO, 14'h0, 3'h0, 8'hFF, 1'b0, 1, 1, 8'h00, 2);
		run(bxu_pkg::OP_DEC_MEM_SKIP_ZERO, 14'h0, 3'h0, 8'h05, 1'b1, 0, 1, 8'h04, 0);
		run(bxu_pkg::OP_DEC_MEM_SKIP_ZERO, 14'h0, 3'h0, 8'h01, 1'b0, 1, 1, 8'h00, 2);
		run(bxu_pkg::OP_INC_MEM_SKIP_ZERO, 14'h0, 3'h0, 8'h7F, 1'b1, 0, 1, 8'h80, 0);
		check("mem_acc", {8'h0, acc}, 16'h0042);
	endtask

	task automatic t_bits();
		bxu_pkg::bxu_op_t tst[4] = '{bxu_pkg::OP_BIT_TEST_SKIP_CLEAR,
			bxu_pkg::OP_BIT_TEST_SKIP_SET, bxu_pkg::OP_BANK0_BIT_TEST_SKIP_CLEAR,
			bxu_pkg::OP_BANK0_BIT_TEST_SKIP_SET};
		bxu_pkg::bxu_op_t wr[4] = '{bxu_pkg::OP_BIT_CLEAR, bxu_pkg::OP_BIT_SET,
			bxu_pkg::OP_BANK0_BIT_CLEAR, bxu_pkg::OP_BANK0_BIT_SET};
		logic [7:0] f, w;
		logic s;
		for (int k = 0; k < 8; k++) begin
			s = (k % 2 == 0) ? ~mdata_bit(k) : mdata_bit(k);
			run(tst[k % 4], 14'h0, 3'(k), 8'h5A, 1'b0, s, 0, 8'h0, s ? 1 : 0);
			check("bank0_tst", {15'h0, s_bank0}, {15'h0, (k % 4) > 1});
		end
		f = flg;
		for (int k = 0; k < 8; k++) begin
			w = (k % 2) ? (8'h5A | (8'h01 << k)) : (8'h5A & ~(8'h01 << k));
			run(wr[k % 4], 14'h0, 3'(k), 8'h5A, k[2], 0, 1, w, k[2] ? 0 : 1);
			check("bank0", {15'h0, s_bank0}, {15'h0, (k % 4) > 1});
		end
		check("bit_flg", {8'h0, flg}, {8'h0, f});
	endtask

	function automatic logic mdata_bit(input int k);
		logic [7:0] m;
		m = 8'h5A;
		return m[k];
	endfunction

	task automatic t_jump();
		@(posedge clk); #1;
		vld = 1'b1; op = bxu_pkg::OP_JUMP; dest = 14'h0ABC; page = 2'h1;
		@(posedge clk); #1;
		op = bxu_pkg::OP_NO_OP;
		@(posedge clk); #1;
		vld = 1'b0;
		@(posedge clk); #1;
		check("refused", pc, 16'h4ABC);
		exp_pc = 16'h4ABC;
		page = 2'h3;
		run(bxu_pkg::OP_JUMP, 14'h3FFF, 3'h0, 8'h00, 1'b0, 0, 0, 8'h0, 1);
		page = 2'h2;
		run(bxu_pkg::OP_JUMP, 14'h1234, 3'h0, 8'h00, 1'b0, 0, 0, 8'h0, 1);
	endtask

	task automatic t_call();
		page = 2'h1;
		run(bxu_pkg::OP_CALL, 14'h0100, 3'h0, 8'h00, 1'b0, 0, 0, 8'h0, 1);
		page = 2'h0;
		run(bxu_pkg::OP_CALL, 14'h2200, 3'h0, 8'h00, 1'b0, 0, 0, 8'h0, 1);
		run(bxu_pkg::OP_SUBROUTINE_RETURN, 14'h0, 3'h0, 8'h00, 1'b0, 0, 0, 8'h0, 1);
		check("gie", {15'h0, gie}, 16'h0000);
		run(bxu_pkg::OP_INTERRUPT_RETURN, 14'h0, 3'h0, 8'h00, 1'b0, 0, 0, 8'h0, 1);
		check("gie", {15'h0, gie}, 16'h0001);
	endtask

	task automatic t_context();
		tovf = 1'b1;
		pdn = 1'b1;
		run(bxu_pkg::OP_COMPARE_SKIP_EQUAL_IMM, 14'h0042, 3'h0, 8'h00, 1'b0, 1, 0, 8'h0, 1);
		run(bxu_pkg::OP_CONTEXT_SAVE, 14'h0, 3'h0, 8'h00, 1'b0, 0, 0, 8'h0, 0);
		run(bxu_pkg::OP_INC_TO_ACC_SKIP_ZERO, 14'h0, 3'h0, 8'h10, 1'b0, 0, 0, 8'h0, 0);
		run(bxu_pkg::OP_COMPARE_SKIP_EQUAL_IMM, 14'h0020, 3'h0, 8'h00, 1'b0, 0, 0, 8'h0, 0);
		check("pre_pop", {acc, flg}, 16'h11C0);
		run(bxu_pkg::OP_CONTEXT_RESTORE, 14'h0, 3'h0, 8'h00, 1'b0, 0, 0, 8'h0, 0);
		check("pop", {acc, flg}, 16'h42C5);
	endtask

	// reset in mid-run: interrupt enable and state must drop, then run again
	task automatic t_mid_reset();
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		t_reset();
		exp_pc = 16'h0000;
		run(bxu_pkg::OP_NO_OP, 14'h0, 3'h0, 8'h00, 1'b0, 0, 0, 8'h0, 0);
		check("rst_acc", {8'h0, acc}, 16'h0000);
	endtask

	// ==========
	// main sequence and watchdog
	initial begin
		repeat (10) @(posedge clk);
		#1 rst = 1'b0;
		@(posedge clk); #1;
		t_reset();
		t_acc();
		t_nop();
		t_compare();
		t_mem();
		t_bits();
		t_jump();
		t_call();
		t_context();
		t_mid_reset();
		stop_test();
	end

	initial begin
		repeat (5000) @(posedge clk);
		num_errors++;
		stop_test();
	end
endmodule
